/* verilog/gpd_pkg.sv */
// Package for the eight-bit port D block: register map, reset values, carriers
package gpd_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int          GPD_PINS       = 8;
    localparam int          GPD_ANALOG     = 3;
    localparam int          GPD_ADDR_W     = 12;
    localparam int          GPD_DATA_W     = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] GPD_OFS_VALUE  = 12'h000;
    localparam logic [11:0] GPD_OFS_DIR    = 12'h004;
    localparam logic [11:0] GPD_OFS_LATCH  = 12'h008;
    localparam logic [11:0] GPD_OFS_ANALOG = 12'h00c;
    localparam logic [11:0] GPD_OFS_PULLUP = 12'h010;
    localparam logic [11:0] GPD_OFS_ODRAIN = 12'h014;
    localparam logic [11:0] GPD_OFS_SLEW   = 12'h018;
    localparam logic [11:0] GPD_OFS_THRESH = 12'h01c;
    localparam logic [11:0] GPD_OFS_OWNER  = 12'h020;
    localparam logic [11:0] GPD_OFS_DRIVE  = 12'h024;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  GPD_RST_DIR    = 8'hff;
    localparam logic [7:0]  GPD_RST_LATCH  = 8'h00;
    localparam logic [2:0]  GPD_RST_ANALOG = 3'h7;
    localparam logic [7:0]  GPD_RST_PULLUP = 8'hff;
    localparam logic [7:0]  GPD_RST_ODRAIN = 8'h00;
    localparam logic [7:0]  GPD_RST_SLEW   = 8'hff;
    localparam logic [7:0]  GPD_RST_THRESH = 8'hff;

    // ----------------------------------------------------------------
    // Field positions of the pins that peripherals can take over
    // ----------------------------------------------------------------
    localparam int          GPD_BIT_OPAMP  = 1;
    localparam int          GPD_BIT_PWM_F  = 4;
    localparam int          GPD_BIT_PWM_E  = 5;
    localparam int          GPD_BIT_PWM_D  = 6;
    localparam int          GPD_BIT_PWM_C  = 7;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // One peripheral output function: enable plus level
    typedef struct packed {
        logic en;
        logic val;
    } gpd_drive_t;

    // All peripheral outputs that compete for port pins
    typedef struct packed {
        gpd_drive_t opamp_three_output;
        gpd_drive_t pwm_ctrl3_output_c;
        gpd_drive_t pwm_ctrl3_output_d;
        gpd_drive_t pwm_ctrl3_output_e;
        gpd_drive_t pwm_ctrl3_output_f;
        gpd_drive_t comparator_three_output;
        gpd_drive_t comparator_four_output;
    } gpd_periph_t;

    // Per-pin pad controls
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] slew_limit;
        logic [7:0] pullup_en;
        logic [7:0] dig_in_en;
    } gpd_pad_t;

endpackage : gpd_pkg

/* verilog/gpd_sync.sv */
// Two-flop synchroniser for the pin readback levels
`timescale 1ns/1ps
`default_nettype none
module gpd_sync
    import gpd_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Levels
    input  wire logic [GPD_PINS-1:0] async_in,
    output logic      [GPD_PINS-1:0] sync_out
);

    logic [GPD_PINS-1:0] meta_reg;

    // First stage feeds the second stage only, to let metastability settle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : gpd_sync
`default_nettype wire

/* verilog/gpd_port.sv */
// Eight-bit general-purpose port D with APB register access
//
// Function
// - eight pins, each direction, latch, readback
// - direction one puts driver in high impedance
// - direction zero drives latch onto pin
// - data read returns pins; write updates latch
// - every port write is read-modify-write
// - direction controls driver even for analog pins
// - analog pins read back as zero
// - open-drain pins only sink, never drive high
// - open-drain cleared gives push-pull drive
// - per-pin slew limit select drives pad
// - threshold select governs readback and on-chip input levels
// - highest priority enabled function owns the pin
// - input functions stay active while pin outputs
// - fixed per-pin priority list ending in latch
// - threshold one selects Schmitt, zero selects TTL
// - analog select on pins 2-0 disables input
// - pull-up disabled while pin is an output
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpd_port
    import gpd_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [GPD_ADDR_W-1:0] paddr,
    input  wire logic [GPD_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [GPD_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Peripheral output functions
    input  wire gpd_periph_t           periph,
    // Pad receivers, one per threshold
    input  wire logic [GPD_PINS-1:0]   pin_schmitt_in,
    input  wire logic [GPD_PINS-1:0]   pin_ttl_in,
    // Pad controls
    output gpd_pad_t                   pad,
    // Synchronised digital levels for on-chip input functions
    output logic      [GPD_PINS-1:0]   pin_level
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]            dir_reg;
    logic [7:0]            dir_next;
    logic [7:0]            latch_reg;
    logic [7:0]            latch_next;
    logic [GPD_ANALOG-1:0] analog_reg;
    logic [GPD_ANALOG-1:0] analog_next;
    logic [7:0]            pullup_reg;
    logic [7:0]            pullup_next;
    logic [7:0]            odrain_reg;
    logic [7:0]            odrain_next;
    logic [7:0]            slew_reg;
    logic [7:0]            slew_next;
    logic [7:0]            thresh_reg;
    logic [7:0]            thresh_next;
    logic [31:0]           rdata_reg;
    logic [31:0]           rdata_next;
    logic                  err_reg;
    logic                  err_next;
    gpd_pad_t              pad_reg;
    gpd_pad_t              pad_next;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Decode happens in the setup cycle so the access cycle answers at once
    wire        setup_rd   = psel & ~penable & ~pwrite;
    wire        setup_any  = psel & ~penable;
    wire        acc_wr     = psel & penable & pwrite;
    wire        lane0      = pstrb[0];
    wire [7:0]  wbyte      = pwdata[7:0];
    wire        hit_value  = (paddr == GPD_OFS_VALUE);
    wire        hit_dir    = (paddr == GPD_OFS_DIR);
    wire        hit_latch  = (paddr == GPD_OFS_LATCH);
    wire        hit_analog = (paddr == GPD_OFS_ANALOG);
    wire        hit_pullup = (paddr == GPD_OFS_PULLUP);
    wire        hit_odrain = (paddr == GPD_OFS_ODRAIN);
    wire        hit_slew   = (paddr == GPD_OFS_SLEW);
    wire        hit_thresh = (paddr == GPD_OFS_THRESH);
    wire        hit_owner  = (paddr == GPD_OFS_OWNER);
    wire        hit_drive  = (paddr == GPD_OFS_DRIVE);
    wire        hit_rw     = hit_value | hit_dir | hit_latch | hit_analog | hit_pullup
                           | hit_odrain | hit_slew | hit_thresh;
    wire        hit_ro     = hit_owner | hit_drive;
    wire        hit_any    = hit_rw | hit_ro;
    // Read-only status words refuse writes with an error
    wire        bad_access = ~hit_any | (pwrite & hit_ro);

    // ----------------------------------------------------------------
    // Pin readback path
    // ----------------------------------------------------------------
    logic [7:0] thr_sel;
    logic [7:0] pin_sync;
    logic [7:0] analog_mask;

    // Threshold pick ahead of the synchroniser; the pick is glitch-prone
    // when changed, which is why software leaves peripherals off then
    assign thr_sel = (thresh_reg & pin_schmitt_in) | (~thresh_reg & pin_ttl_in);

    gpd_sync u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (thr_sel),
        .sync_out (pin_sync)
    );

    // Analog pins have no digital buffer, so they read zero
    assign analog_mask = {5'h00, analog_reg};
    assign pin_level   = pin_sync & ~analog_mask;

    // ----------------------------------------------------------------
    // Output priority multiplexer
    // ----------------------------------------------------------------
    logic [7:0] sel_val;
    logic [7:0] owned;

    // Pins 0, 2 and 3 carry only the latch
    assign sel_val[0] = latch_reg[0];
    assign sel_val[2] = latch_reg[2];
    assign sel_val[3] = latch_reg[3];
    // Op-amp takes pin 1 ahead of the latch
    assign sel_val[GPD_BIT_OPAMP] = periph.opamp_three_output.en
                                  ? periph.opamp_three_output.val
                                  : latch_reg[GPD_BIT_OPAMP];
    assign sel_val[GPD_BIT_PWM_F] = periph.pwm_ctrl3_output_f.en
                                  ? periph.pwm_ctrl3_output_f.val
                                  : latch_reg[GPD_BIT_PWM_F];
    assign sel_val[GPD_BIT_PWM_E] = periph.pwm_ctrl3_output_e.en
                                  ? periph.pwm_ctrl3_output_e.val
                                  : latch_reg[GPD_BIT_PWM_E];
    // PWM wins over the comparator, which wins over the latch
    assign sel_val[GPD_BIT_PWM_D] = periph.pwm_ctrl3_output_d.en
                                  ? periph.pwm_ctrl3_output_d.val
                                  : periph.comparator_three_output.en
                                  ? periph.comparator_three_output.val
                                  : latch_reg[GPD_BIT_PWM_D];
    assign sel_val[GPD_BIT_PWM_C] = periph.pwm_ctrl3_output_c.en
                                  ? periph.pwm_ctrl3_output_c.val
                                  : periph.comparator_four_output.en
                                  ? periph.comparator_four_output.val
                                  : latch_reg[GPD_BIT_PWM_C];

    // Which pins a peripheral currently owns, for the status word
    assign owned = {periph.pwm_ctrl3_output_c.en | periph.comparator_four_output.en,
                    periph.pwm_ctrl3_output_d.en | periph.comparator_three_output.en,
                    periph.pwm_ctrl3_output_e.en,
                    periph.pwm_ctrl3_output_f.en,
                    2'b00,
                    periph.opamp_three_output.en,
                    1'b0};

    // ----------------------------------------------------------------
    // Pad control, one stage per pin
    // ----------------------------------------------------------------
    // A peripheral still needs its direction bit cleared to reach the pin
    for (genvar i = 0; i < GPD_PINS; i++) begin : g_pad
        wire out_mode = ~dir_reg[i];
        // One continuous driver per bit keeps each pad bit single-sourced
        assign pad_next.out[i]        = sel_val[i] & ~odrain_reg[i];
        assign pad_next.oe[i]         = out_mode & (~odrain_reg[i] | ~sel_val[i]);
        assign pad_next.slew_limit[i] = slew_reg[i];
        assign pad_next.pullup_en[i]  = pullup_reg[i] & dir_reg[i];
        assign pad_next.dig_in_en[i]  = ~analog_mask[i];
    end

    // Pad drivers come from flops so the pins see no decode glitches
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pad_reg <= '{out: 8'h00, oe: 8'h00, slew_limit: GPD_RST_SLEW,
                         pullup_en: 8'h00, dig_in_en: 8'h00};
        end else begin
            pad_reg <= pad_next;
        end
    end
    assign pad = pad_reg;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Latch write through the data word: pins are read, the byte lane
    // modifies them, and the result goes to the latch. A write without
    // lane 0 still copies the current pin levels into the latch.
    wire        wr_value   = acc_wr & hit_value;
    wire [7:0]  rmw_value  = lane0 ? wbyte : pin_level;
    wire        wr_lane    = acc_wr & lane0;

    assign latch_next  = wr_value              ? rmw_value
                       : (wr_lane & hit_latch) ? wbyte : latch_reg;
    assign dir_next    = (wr_lane & hit_dir)    ? wbyte : dir_reg;
    assign analog_next = (wr_lane & hit_analog) ? wbyte[GPD_ANALOG-1:0] : analog_reg;
    assign pullup_next = (wr_lane & hit_pullup) ? wbyte : pullup_reg;
    assign odrain_next = (wr_lane & hit_odrain) ? wbyte : odrain_reg;
    assign slew_next   = (wr_lane & hit_slew)   ? wbyte : slew_reg;
    assign thresh_next = (wr_lane & hit_thresh) ? wbyte : thresh_reg;

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dir_reg    <= GPD_RST_DIR;
            latch_reg  <= GPD_RST_LATCH;
            analog_reg <= GPD_RST_ANALOG;
            pullup_reg <= GPD_RST_PULLUP;
            odrain_reg <= GPD_RST_ODRAIN;
            slew_reg   <= GPD_RST_SLEW;
            thresh_reg <= GPD_RST_THRESH;
        end else begin
            dir_reg    <= dir_next;
            latch_reg  <= latch_next;
            analog_reg <= analog_next;
            pullup_reg <= pullup_next;
            odrain_reg <= odrain_next;
            slew_reg   <= slew_next;
            thresh_reg <= thresh_next;
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Read data is captured in the setup cycle; the byte sits in the low
    // lane and upper bits read zero
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (1'b1)
            hit_value:  rd_byte = pin_level;
            hit_dir:    rd_byte = dir_reg;
            hit_latch:  rd_byte = latch_reg;
            hit_analog: rd_byte = analog_mask;
            hit_pullup: rd_byte = pullup_reg;
            hit_odrain: rd_byte = odrain_reg;
            hit_slew:   rd_byte = slew_reg;
            hit_thresh: rd_byte = thresh_reg;
            hit_owner:  rd_byte = owned;
            hit_drive:  rd_byte = pad_reg.oe;
            default:    rd_byte = 8'h00;
        endcase
    end

    assign rdata_next = setup_rd  ? {24'h000000, rd_byte} : rdata_reg;
    assign err_next   = setup_any ? bad_access : err_reg;

    // Answer registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
        end
    end

    // Zero wait states: every access phase completes on its first edge
    assign pready  = 1'b1;
    assign prdata  = rdata_reg;
    assign pslverr = err_reg & psel & penable;

endmodule : gpd_port
`default_nettype wire

/* verif/gpd_checker.sv */
// Concurrent checks on the port D block, watching its ports only
`timescale 1ns/1ps
`default_nettype none
module gpd_checker
    import gpd_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst,
    // Register bus
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [GPD_ADDR_W-1:0] paddr,
    input wire logic [GPD_DATA_W-1:0] pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [GPD_DATA_W-1:0] prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Pins and peripherals
    input wire gpd_periph_t           periph,
    input wire logic [GPD_PINS-1:0]   pin_schmitt_in,
    input wire logic [GPD_PINS-1:0]   pin_ttl_in,
    input wire gpd_pad_t              pad,
    input wire logic [GPD_PINS-1:0]   pin_level
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    // Access edge of a write with the low byte enabled
    sequence wr_acc(logic [11:0] ofs);
        psel && penable && pwrite && pstrb[0] && paddr == ofs;
    endsequence
    // PWM F owns pin 4 at low level and the driver is on
    sequence pwm_f_low;
        periph.pwm_ctrl3_output_f.en && !periph.pwm_ctrl3_output_f.val ##1 pad.oe[4];
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access phase");
    unmapped_err_a: assert property (psel && penable && paddr > 12'h024 |-> pslverr)
        else $error("unmapped access not refused");
    dir_hiz_a: assert property (wr_acc(GPD_OFS_DIR) ##0 pwdata[7:0] == 8'hff
        |-> ##2 pad.oe == 8'h00) else $error("input pins still driven");
    pullup_off_a: assert property (wr_acc(GPD_OFS_DIR) ##0 pwdata[7:0] == 8'h00
        |-> ##2 pad.pullup_en == 8'h00) else $error("pull-up on while output");
    od_sink_a: assert property (wr_acc(GPD_OFS_ODRAIN) ##0 pwdata[7:0] == 8'hff
        |-> ##2 pad.out == 8'h00) else $error("open-drain pin driven high");
    slew_sel_a: assert property (wr_acc(GPD_OFS_SLEW)
        |-> ##2 pad.slew_limit == $past(pwdata[7:0], 2)) else $error("slew select lost");
    pwm_low_a: assert property (pwm_f_low |-> !pad.out[4])
        else $error("pin 4 not low under PWM F");
    pwm_high_a: assert property (periph.pwm_ctrl3_output_e.en &&
        periph.pwm_ctrl3_output_e.val ##1 pad.oe[5] |-> pad.out[5])
        else $error("pin 5 not high under PWM E");
    pin6_prio_a: assert property (periph.pwm_ctrl3_output_d.en &&
        periph.pwm_ctrl3_output_d.val && periph.comparator_three_output.en &&
        !periph.comparator_three_output.val ##1 pad.oe[6] |-> pad.out[6])
        else $error("comparator beat PWM D on pin 6");
    analog_zero_a: assert property (pin_level[0] |=> pad.dig_in_en[0])
        else $error("analog pin reads high");
endmodule : gpd_checker
`default_nettype wire

/* verif/gpd_pin_model.sv */
// Behavioural model of the board wiring and receivers behind the pads
`timescale 1ns/1ps
`default_nettype none
module gpd_pin_model
    import gpd_pkg::*;
(
    // Clock
    input wire logic                clk_sys,
    // Pad side
    input wire gpd_pad_t            pad,
    // Outside sources
    input wire logic [GPD_PINS-1:0] ext_en,
    input wire logic [GPD_PINS-1:0] ext_val,
    input wire logic [GPD_PINS-1:0] ttl_skew,
    // Receivers
    output logic     [GPD_PINS-1:0] pin_schmitt_in,
    output logic     [GPD_PINS-1:0] pin_ttl_in
);
    logic [7:0] float_q;
    logic [7:0] wire_lvl;

    // Undriven pins without pull-up wander each cycle so nothing reads right by luck
    initial float_q = 8'h00;
    always @(posedge clk_sys) float_q <= ~float_q;

    // Pad driver wins, then the outside source, then pull-up or wander
    assign wire_lvl = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
                    | (~pad.oe & ~ext_en & (pad.pullup_en | float_q));
    assign pin_schmitt_in = wire_lvl;
    assign pin_ttl_in     = wire_lvl ^ ttl_skew; // Receivers may disagree near threshold
endmodule : gpd_pin_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the port D block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import gpd_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, rerr;
    gpd_periph_t periph = '0;
    logic [7:0] schm, ttl, lvl, ext_en = 8'h00, ext_val = 8'h00, ttl_skew = 8'h00;
    gpd_pad_t pad;
    int err_count = 0, comparisons = 0;

    // Clock: 8 ns period
    always #4 clk_sys = ~clk_sys;

    gpd_port gpd_port_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph(periph), .pin_schmitt_in(schm),
        .pin_ttl_in(ttl), .pad(pad), .pin_level(lvl));
    gpd_pin_model gpd_pin_model_i (.clk_sys(clk_sys), .pad(pad), .ext_en(ext_en),
        .ext_val(ext_val), .ttl_skew(ttl_skew), .pin_schmitt_in(schm), .pin_ttl_in(ttl));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    // One APB transfer; holds everything until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'h1);
    endtask : wr
    task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, 4'h1);
        chk(n, {24'h0, e}, rdat);
        chk({n, " error"}, 32'h0, {31'h0, rerr});
    endtask : rd
    // Pads lag a write by one edge, pin readback by two more
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask : settle

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [11:0] ofs [7] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c};
        logic [7:0]  rv  [7] = '{8'hff, 8'h00, 8'h07, 8'hff, 8'h00, 8'hff, 8'hff};
        for (int i = 0; i < 7; i++) rd("reset value", ofs[i], rv[i]);
        chk("reset oe", 32'h0, {24'h0, pad.oe});
        chk("reset digital in", 32'hf8, {24'h0, pad.dig_in_en});
        $display("test reset done");
    endtask : t_reset
    task automatic t_out();
        wr(GPD_OFS_DIR, 8'h00);
        wr(GPD_OFS_LATCH, 8'ha5);
        settle();
        chk("driven oe", 32'hff, {24'h0, pad.oe});
        chk("driven out", 32'ha5, {24'h0, pad.out});
        rd("analog read", GPD_OFS_VALUE, 8'ha0);
        chk("pin level", 32'ha0, {24'h0, lvl});
        wr(GPD_OFS_ANALOG, 8'h00);
        settle();
        rd("digital read", GPD_OFS_VALUE, 8'ha5);
        $display("test output done");
    endtask : t_out
    task automatic t_in();
        wr(GPD_OFS_DIR, 8'hff);
        @(posedge clk_sys);
        ext_en <= 8'hff; ext_val <= 8'h3c; ttl_skew <= 8'h0f;
        settle();
        chk("input oe", 32'h0, {24'h0, pad.oe});
        rd("schmitt read", GPD_OFS_VALUE, 8'h3c);
        wr(GPD_OFS_THRESH, 8'h00);
        settle();
        rd("ttl read", GPD_OFS_VALUE, 8'h33);
        wr(GPD_OFS_THRESH, 8'hff);
        $display("test input done");
    endtask : t_in
    task automatic t_rmw();
        wr(GPD_OFS_DIR, 8'hf0);
        wr(GPD_OFS_LATCH, 8'h05);
        @(posedge clk_sys);
        ext_en <= 8'hf0; ext_val <= 8'ha0;
        settle();
        apb(1'b1, GPD_OFS_VALUE, 32'h0, 4'h0);
        rd("rmw latch", GPD_OFS_LATCH, 8'ha5);
        apb(1'b1, GPD_OFS_VALUE, 32'hc3, 4'h1);
        rd("write latch", GPD_OFS_LATCH, 8'hc3);
        @(posedge clk_sys);
        ext_en <= 8'h00;
        $display("test rmw done");
    endtask : t_rmw
    task automatic t_od();
        wr(GPD_OFS_DIR, 8'h00);
        wr(GPD_OFS_LATCH, 8'h0f);
        wr(GPD_OFS_ODRAIN, 8'hff);
        settle();
        chk("od out", 32'h00, {24'h0, pad.out});
        chk("od oe", 32'hf0, {24'h0, pad.oe});
        chk("pullup", 32'h00, {24'h0, pad.pullup_en});
        rd("drive status", GPD_OFS_DRIVE, 8'hf0);
        wr(GPD_OFS_ODRAIN, 8'h00);
        wr(GPD_OFS_SLEW, 8'h5a);
        settle();
        chk("pp out", 32'h0f, {24'h0, pad.out});
        chk("slew", 32'h5a, {24'h0, pad.slew_limit});
        $display("test drive done");
    endtask : t_od
    task automatic t_prio();
        wr(GPD_OFS_LATCH, 8'h00);
        @(posedge clk_sys);
        periph <= 14'b11111110111010;
        settle();
        chk("prio out", 32'hd2, {24'h0, pad.out});
        rd("owner", GPD_OFS_OWNER, 8'hf2);
        rd("owned read", GPD_OFS_VALUE, 8'hd2);
        @(posedge clk_sys);
        periph <= 14'b11000011101110;
        settle();
        chk("fallback out", 32'h62, {24'h0, pad.out});
        @(posedge clk_sys);
        periph <= '0;
        $display("test priority done");
    endtask : t_prio
    task automatic t_err();
        apb(1'b0, 12'h040, 32'h0, 4'h1);
        chk("unmapped data", 32'h0, rdat);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        apb(1'b1, GPD_OFS_OWNER, 32'hff, 4'h1);
        chk("read-only error", 32'h1, {31'h0, rerr});
        $display("test errors done");
    endtask : t_err

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Main sequence after eight reset cycles
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_out();
        t_in();
        t_rmw();
        t_od();
        t_prio();
        t_err();
        end_sim();
    end

    // Watchdog far beyond the expected run
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule : testbench

bind gpd_port gpd_checker gpd_checker_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph),
    .pin_schmitt_in(pin_schmitt_in), .pin_ttl_in(pin_ttl_in), .pad(pad),
    .pin_level(pin_level));
`default_nettype wire
